// File: acrb_pkg.sv
// Purpose: Constants for the converter control register bank
// Assumes: Byte-wide registers on an internal register port
// Notes: Shadow and active copies; commit applies all at once
//
// What this block does
// RL1: The power field uses 00 for normal operation, 10 for standby, and 11 is reserved.
// RL2: Power field code 01 puts the whole converter into full power-down once committed.
// RL3: The three-bit divide ratio codes 000 to 111 divide the input clock by 1 to 8.
// RL4: The three-bit phase field delays the divided clock by 0 to 7 input cycles, 000 meaning none.
// RL5: Test register bit 7 clear repeats the pattern; set emits it once and then zeros.
// RL6: A nonzero test mode puts generated test data on the output port instead of samples.
// RL7: Shadowed writes take no effect until 0x01 is written to the transfer address, then all apply together.
// RL8: After the shadowed values are applied the transfer bit clears by itself.
`default_nettype none
package acrb_pkg;
	localparam logic [7:0] ADDR_POWER = 8'h08;
	localparam logic [7:0] ADDR_GCLK = 8'h09;
	localparam logic [7:0] ADDR_CDIV = 8'h0B;
	localparam logic [7:0] ADDR_TEST = 8'h0D;
	localparam logic [7:0] ADDR_OFFS = 8'h10;
	localparam logic [7:0] ADDR_COMMIT = 8'hFF;
	localparam logic [7:0] RST_POWER = 8'h00;
	localparam logic [7:0] RST_GCLK = 8'h01;
	localparam logic [7:0] RST_CDIV = 8'h00;
	localparam logic [7:0] RST_TEST = 8'h00;
	localparam logic [7:0] RST_OFFS = 8'h00;
	localparam logic [7:0] COMMIT_CMD = 8'h01;
	localparam logic [1:0] PWR_NORMAL = 2'h0;
	localparam logic [1:0] PWR_FULLDOWN = 2'h1;
	localparam logic [1:0] PWR_STANDBY = 2'h2;
	localparam logic [1:0] PWR_RESERVED = 2'h3;
	localparam int POWER_LSB = 0;
	localparam int RATIO_LSB = 0;
	localparam int PHASE_LSB = 3;
	localparam int TMODE_LSB = 0;
	localparam int ONCE_BIT = 7;
	localparam int DCS_BIT = 0;
	localparam int OFFS_W = 6;
endpackage
`default_nettype wire

// File: acrb_cfg_if.sv
// Purpose: Carries the committed settings between the bank and the divider
// Assumes: Single clock
// Notes: None
`timescale 1ns/1ps
`default_nettype none
interface acrb_cfg_if;
	logic [2:0] ratio;
	logic [2:0] phase;
	logic powered;
	logic div_clk;
	modport bank (output ratio, output phase, output powered, input div_clk);
	modport div (input ratio, input phase, input powered, output div_clk);
endinterface
`default_nettype wire

// File: acrb_divider.sv
// Purpose: Divides the input clock enable stream by 1 to 8 with a phase delay
// Assumes: Input clock is clk_i, qualified by ce_i
// Notes: Output is a one-cycle tick per divided period
`timescale 1ns/1ps
`default_nettype none
module acrb_divider (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Settings
	acrb_cfg_if.div cfg
);
	logic [2:0] cnt_q, cnt_d;
	logic [6:0] dly_q, dly_d;
	logic tick;

	always_comb
	begin
		// Catch up at once when a smaller ratio is committed below the count
		tick = cfg.powered && (cnt_q >= cfg.ratio); // [RL3]
		cnt_d = cnt_q;
		if (!cfg.powered || tick)
			cnt_d = 3'h0;
		else
			cnt_d = cnt_q + 3'h1;
		dly_d = {dly_q[5:0], tick};
	end

	// Delay line: tap 0 is the tick one cycle late; phase 0 takes the undelayed tick
	// Delayed ticks still in the line must not leak out after power-down
	assign cfg.div_clk = cfg.powered && ((cfg.phase == 3'h0) ? tick : dly_q[cfg.phase - 3'h1]); // [RL4]

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_q <= 3'h0;
			dly_q <= 7'h00;
		end
		else if (ce_i)
		begin
			cnt_q <= cnt_d;
			dly_q <= dly_d;
		end
	end
endmodule
`default_nettype wire

// File: acrb_bank.sv
// Purpose: Shadowed control register bank of the converter
// Assumes: Register port writes and reads one byte per cycle
// Notes: Pattern generator here is a simple stand-in ramp
`timescale 1ns/1ps
`default_nettype none
module acrb_bank #(
	parameter int DATA_W = 12
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Register port
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	// Converter core
	input wire logic [DATA_W-1:0] sample_i,
	output logic [DATA_W-1:0] data_o,
	output logic powerdown_o,
	output logic standby_o,
	output logic dcs_en_o,
	output logic [acrb_pkg::OFFS_W-1:0] offset_o,
	output logic div_clk_o
);
	logic [7:0] sh_pwr_q, sh_pwr_d, sh_gclk_q, sh_gclk_d, sh_cdiv_q, sh_cdiv_d;
	logic [7:0] sh_test_q, sh_test_d, sh_offs_q, sh_offs_d;
	logic [7:0] ac_pwr_q, ac_pwr_d, ac_gclk_q, ac_gclk_d, ac_cdiv_q, ac_cdiv_d;
	logic [7:0] ac_test_q, ac_test_d, ac_offs_q, ac_offs_d;
	logic commit_q, commit_d;
	logic [7:0] rdata_q, rdata_d;
	logic [DATA_W-1:0] pat_q, pat_d, data_q, data_d;
	logic done_q, done_d;
	logic [1:0] pmode;
	logic [3:0] tmode;
	acrb_cfg_if cfg ();

	acrb_divider u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.cfg(cfg)
	);

	assign pmode = ac_pwr_q[acrb_pkg::POWER_LSB +: 2];
	assign tmode = ac_test_q[acrb_pkg::TMODE_LSB +: 4];
	assign cfg.ratio = ac_cdiv_q[acrb_pkg::RATIO_LSB +: 3];
	assign cfg.phase = ac_cdiv_q[acrb_pkg::PHASE_LSB +: 3];
	assign cfg.powered = (pmode == acrb_pkg::PWR_NORMAL);
	assign powerdown_o = (pmode == acrb_pkg::PWR_FULLDOWN); // [RL2]
	assign standby_o = (pmode == acrb_pkg::PWR_STANDBY); // [RL1]
	// Divide ratios other than 1 force the stabilizer on
	assign dcs_en_o = ac_gclk_q[acrb_pkg::DCS_BIT] || (cfg.ratio != 3'h0);
	assign offset_o = ac_offs_q[acrb_pkg::OFFS_W-1:0];
	assign div_clk_o = cfg.div_clk;
	assign rdata_o = rdata_q;
	assign data_o = data_q;

	always_comb
	begin
		sh_pwr_d = sh_pwr_q;
		sh_gclk_d = sh_gclk_q;
		sh_cdiv_d = sh_cdiv_q;
		sh_test_d = sh_test_q;
		sh_offs_d = sh_offs_q;
		commit_d = 1'b0; // [RL8]
		if (wr_i)
		begin
			case (addr_i)
				acrb_pkg::ADDR_POWER:
				begin
					// Reserved code is refused; the old setting stays
					if (wdata_i[1:0] != acrb_pkg::PWR_RESERVED) // [RL1]
						sh_pwr_d = {6'h00, wdata_i[1:0]};
				end
				acrb_pkg::ADDR_GCLK: sh_gclk_d = {7'h00, wdata_i[0]};
				acrb_pkg::ADDR_CDIV: sh_cdiv_d = {2'h0, wdata_i[5:0]};
				acrb_pkg::ADDR_TEST: sh_test_d = {wdata_i[7], 3'h0, wdata_i[3:0]};
				acrb_pkg::ADDR_OFFS: sh_offs_d = {2'h0, wdata_i[5:0]};
				acrb_pkg::ADDR_COMMIT: commit_d = (wdata_i == acrb_pkg::COMMIT_CMD); // [RL7]
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sh_pwr_q <= acrb_pkg::RST_POWER;
			sh_gclk_q <= acrb_pkg::RST_GCLK;
			sh_cdiv_q <= acrb_pkg::RST_CDIV;
			sh_test_q <= acrb_pkg::RST_TEST;
			sh_offs_q <= acrb_pkg::RST_OFFS;
			commit_q <= 1'b0;
		end
		else if (ce_i)
		begin
			sh_pwr_q <= sh_pwr_d;
			sh_gclk_q <= sh_gclk_d;
			sh_cdiv_q <= sh_cdiv_d;
			sh_test_q <= sh_test_d;
			sh_offs_q <= sh_offs_d;
			commit_q <= commit_d;
		end
	end

	// Commit copies every shadow at once, one cycle after the command
	always_comb
	begin
		ac_pwr_d = commit_q ? sh_pwr_q : ac_pwr_q; // [RL7]
		ac_gclk_d = commit_q ? sh_gclk_q : ac_gclk_q;
		ac_cdiv_d = commit_q ? sh_cdiv_q : ac_cdiv_q;
		ac_test_d = commit_q ? sh_test_q : ac_test_q;
		ac_offs_d = commit_q ? sh_offs_q : ac_offs_q;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ac_pwr_q <= acrb_pkg::RST_POWER;
			ac_gclk_q <= acrb_pkg::RST_GCLK;
			ac_cdiv_q <= acrb_pkg::RST_CDIV;
			ac_test_q <= acrb_pkg::RST_TEST;
			ac_offs_q <= acrb_pkg::RST_OFFS;
		end
		else if (ce_i)
		begin
			ac_pwr_q <= ac_pwr_d;
			ac_gclk_q <= ac_gclk_d;
			ac_cdiv_q <= ac_cdiv_d;
			ac_test_q <= ac_test_d;
			ac_offs_q <= ac_offs_d;
		end
	end

	always_comb
	begin
		rdata_d = rdata_q;
		if (rd_i)
		begin
			case (addr_i)
				acrb_pkg::ADDR_POWER: rdata_d = sh_pwr_q;
				acrb_pkg::ADDR_GCLK: rdata_d = sh_gclk_q;
				acrb_pkg::ADDR_CDIV: rdata_d = sh_cdiv_q;
				acrb_pkg::ADDR_TEST: rdata_d = sh_test_q;
				acrb_pkg::ADDR_OFFS: rdata_d = sh_offs_q;
				acrb_pkg::ADDR_COMMIT: rdata_d = {7'h00, commit_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Reads return the shadow copy so settings can be checked before commit
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_q <= 8'h00;
		else if (ce_i)
			rdata_q <= rdata_d;
	end

	always_comb
	begin
		pat_d = pat_q;
		done_d = done_q;
		if (commit_q)
		begin
			pat_d = '0;
			done_d = 1'b0;
		end
		else if (tmode != 4'h0 && cfg.div_clk)
		begin
			pat_d = pat_q + {{(DATA_W-1){1'b0}}, 1'b1};
			if (ac_test_q[acrb_pkg::ONCE_BIT] && (&pat_q)) // [RL5]
				done_d = 1'b1;
		end
	end

	// Output word changes only on divided clock ticks
	always_comb
	begin
		data_d = data_q;
		if (cfg.div_clk)
		begin
			if (tmode == 4'h0)
				data_d = sample_i;
			else if (done_q) // [RL5]
				data_d = '0;
			else
				data_d = pat_q; // [RL6]
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pat_q <= '0;
			done_q <= 1'b0;
		end
		else if (ce_i)
		begin
			pat_q <= pat_d;
			done_q <= done_d;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			data_q <= '0;
		else if (ce_i)
			data_q <= data_d;
	end
endmodule
`default_nettype wire

// File: acrb_bank_asserts.sv
// Purpose: Checks the bank outputs against commit rules
// Assumes: ce_i high around commits
// Notes: Bound to acrb_bank
`timescale 1ns/1ps
`default_nettype none
module acrb_bank_asserts #(
	parameter int DATA_W = 12
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Register port
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o,
	// Converter side
	input wire logic [DATA_W-1:0] data_o,
	input wire logic powerdown_o,
	input wire logic standby_o,
	input wire logic dcs_en_o,
	input wire logic [acrb_pkg::OFFS_W-1:0] offset_o,
	input wire logic div_clk_o
);
	logic cmd;
	logic rd_ff;
	assign cmd = ce_i && wr_i && addr_i == 8'hFF && wdata_i == 8'h01;
	assign rd_ff = ce_i && rd_i && addr_i == 8'hFF;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_power_excl: assert property (!(powerdown_o && standby_o))
		else $error("power modes overlap");
	a_clk_gated: assert property (powerdown_o || standby_o |-> !div_clk_o)
		else $error("tick while powered down");
	a_data_hold: assert property (!div_clk_o |=> $stable(data_o))
		else $error("data moved without tick");
	a_power_hold: assert property (!$past(cmd, 2) |-> $stable({powerdown_o, standby_o}))
		else $error("power moved without commit");
	a_trim_hold: assert property (!$past(cmd, 2) |-> $stable(offset_o))
		else $error("trim moved without commit");
	a_dcs_hold: assert property (!$past(cmd, 2) |-> $stable(dcs_en_o))
		else $error("dcs moved without commit");
	a_commit_seen: assert property (rd_ff && $past(cmd) |=> rdata_o == 8'h01)
		else $error("commit bit not seen");
	a_commit_clear: assert property (rd_ff && !$past(cmd) |=> rdata_o == 8'h00)
		else $error("commit bit stuck");
	a_freeze_hold: assert property (!ce_i |=> $stable({rdata_o, data_o, offset_o, div_clk_o}) &&
		$stable({powerdown_o, standby_o, dcs_en_o}))
		else $error("outputs moved while frozen");
	c_freeze: cover property (!ce_i);
	c_commit: cover property (cmd);
	c_down: cover property (powerdown_o);
	c_standby: cover property (standby_o);
endmodule
bind acrb_bank acrb_bank_asserts #(.DATA_W(DATA_W)) chk_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .data_o(data_o),
	.powerdown_o(powerdown_o), .standby_o(standby_o), .dcs_en_o(dcs_en_o), .offset_o(offset_o),
	.div_clk_o(div_clk_o));
`default_nettype wire

// File: acrb_host.sv
// Purpose: Host model driving the register port
// Assumes: Tasks start just after a rising edge
// Notes: Released write data is inverted
`timescale 1ns/1ps
`default_nettype none
module acrb_host (
	// Clock and answer
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	// Register port
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o
);
	initial
	begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(posedge clk_i);
		d = rdata_i;
	endtask
	// Gap cycle keeps the write strobe from being set twice in one step
	task commit;
		@(posedge clk_i);
		wr(8'hFF, 8'h01);
	endtask
endmodule
`default_nettype wire

// File: acrb_bank_tb.sv
// Purpose: Self-checking bench for the bank
// Assumes: ce_i high except in the freeze test
// Notes: Rows cover shadow writes and commits
`timescale 1ns/1ps
`default_nettype none
module acrb_bank_tb;
	typedef struct {logic [7:0] a, d, r; logic [8:0] o;} acrb_row_type;
	acrb_row_type rows [8] = '{'{8'h08, 8'h01, 8'h01, 9'h140}, '{8'h08, 8'h02, 8'h02, 9'h0C0},
		'{8'h08, 8'h00, 8'h00, 9'h040}, '{8'h09, 8'h00, 8'h00, 9'h000}, '{8'h0B, 8'h01, 8'h01, 9'h040},
		'{8'h0B, 8'h38, 8'h38, 9'h000}, '{8'h10, 8'h3F, 8'h3F, 9'h03F}, '{8'h09, 8'h01, 8'h01, 9'h07F}};
	logic clk_i, rst_i, ce, wr, rd, pd, sb, dcs, tick;
	logic [7:0] addr, wdata, rdata, v;
	logic [11:0] data, p, smp;
	logic [5:0] offs;
	int num_errors, tests_run, n;
	acrb_bank acrb_bank_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wr_i(wr), .rd_i(rd), .addr_i(addr),
		.wdata_i(wdata), .rdata_o(rdata), .sample_i(smp), .data_o(data), .powerdown_o(pd),
		.standby_o(sb), .dcs_en_o(dcs), .offset_o(offs), .div_clk_o(tick));
	acrb_host acrb_host_i (.clk_i(clk_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr),
		.wdata_o(wdata));
	task check(input logic [11:0] s, input logic [11:0] e);
		tests_run++;
		if (s !== e)
		begin
			num_errors++;
			$display("wrong value at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		finish_test;
	end
	initial
	begin
		rst_i = 1'b1;
		ce = 1'b1;
		smp = 12'hABC;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		foreach (rows[k])
		begin
			acrb_host_i.wr(rows[k].a, rows[k].d);
			acrb_host_i.rd(rows[k].a, v);
			check(12'(v), 12'(rows[k].r));
			acrb_host_i.commit;
			acrb_host_i.rd(8'hFF, v);
			check(12'(v), 12'h001);
			acrb_host_i.rd(8'hFF, v);
			check(12'(v), 12'h000);
			check(12'({pd, sb, dcs, offs}), 12'(rows[k].o));
			$display("row %0d done", k);
		end
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check(12'({pd, sb, dcs, offs}), 12'h040);
		foreach (rows[k])
		begin
			acrb_host_i.rd(rows[k].a, v);
			check(12'(v), 12'(rows[k].a == 8'h09));
		end
		acrb_host_i.rd(8'h20, v);
		check(12'(v), 12'h000);
		acrb_host_i.wr(8'h08, 8'h03);
		acrb_host_i.rd(8'h08, v);
		check(12'(v), 12'h000);
		ce <= 1'b0;
		acrb_host_i.wr(8'h10, 8'h15);
		ce <= 1'b1;
		acrb_host_i.rd(8'h10, v);
		check(12'(v), 12'h000);
		$display("reset and reserved done");
		for (int r = 0; r < 8; r++)
		begin
			acrb_host_i.wr(8'h0B, 8'(r * 9));
			acrb_host_i.commit;
			repeat (3) @(posedge clk_i);
			n = 0;
			repeat (8 * (r + 1)) @(negedge clk_i) n += tick;
			check(12'(n), 12'h008);
			@(posedge clk_i);
		end
		acrb_host_i.wr(8'h0B, 8'h00);
		acrb_host_i.commit;
		smp <= 12'h5A3;
		repeat (3) @(negedge clk_i);
		check(data, 12'h5A3);
		@(posedge clk_i);
		acrb_host_i.wr(8'h0D, 8'h0F);
		acrb_host_i.commit;
		repeat (4) @(negedge clk_i);
		p = data;
		@(negedge clk_i);
		check(data, p + 12'h001);
		@(posedge clk_i);
		acrb_host_i.wr(8'h0D, 8'h8F);
		acrb_host_i.commit;
		repeat (4200) @(negedge clk_i);
		check(data, 12'h000);
		$display("divider and pattern done");
		finish_test;
	end
endmodule
`default_nettype wire
